//--- rtl/uht_timer_ctrl.v
// upper timer control: control registers over AXI4-Lite, effective
// control selection (own or paired), idle halt, gating, source select
// and prescaling; emits count enables for the upper word.
// assumes idle, gate and pin come from outside the clock domain.
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "uht_map.vh"

// Summary of operation
// R1: a set run bit makes the upper 16-bit timer count, a clear one stops it.
// R2: with idle halt set the timer stops while the cpu idles, else it runs.
// R3: gating applies with the internal clock only; external source ignores it.
// R4: prescale code 11, 10, 01, 00 divides the input by 256, 64, 8, 1.
// R5: source bit 1 counts external pin rising edges, 0 the peripheral clock.
// R6: in wide pair mode the upper control bits are ignored for the lower's.
// R7: software must clear lower idle halt to keep the pair running in idle.
// R8: pair bit 1 joins both timers into one 32-bit timer, 0 keeps two.
// R9: in the pair the upper timer holds the high word, the lower the low.
// R10: the external pin is synchronised before edge detection.
module uht_timer_ctrl
(
   input  wire        clk_i,          // peripheral clock, 100 MHz
   input  wire        nrst_i,         // async reset, active low
   input  wire [3:0]  s_axi_awaddr,   // write address
   input  wire        s_axi_awvalid,  // write address valid
   output reg         s_axi_awready,  // write address ready
   input  wire [31:0] s_axi_wdata,    // write data
   input  wire [3:0]  s_axi_wstrb,    // write byte strobes
   input  wire        s_axi_wvalid,   // write data valid
   output reg         s_axi_wready,   // write data ready
   output reg  [1:0]  s_axi_bresp,    // write response
   output reg         s_axi_bvalid,   // write response valid
   input  wire        s_axi_bready,   // write response ready
   input  wire [3:0]  s_axi_araddr,   // read address
   input  wire        s_axi_arvalid,  // read address valid
   output reg         s_axi_arready,  // read address ready
   output reg  [31:0] s_axi_rdata,    // read data
   output reg  [1:0]  s_axi_rresp,    // read response
   output reg         s_axi_rvalid,   // read data valid
   input  wire        s_axi_rready,   // read data ready
   input  wire        cpu_idle_i,     // cpu in idle mode
   input  wire        gate_in_i,      // gate input for accumulation
   input  wire        external_count_pin_i, // external clock pin
   output reg         upper_count_en_o, // advance 16-bit upper timer
   output reg         gate_fall_o,    // end of gated window
   output reg         pair_wide_mode_o, // pair acts as 32-bit
   output reg         pair_carry_sel_o  // pair count pulse: prescaled tick in wide mode, advances the low word
);

   reg [15:0] upper_timer_control_reg;
   reg [15:0] lower_timer_control_reg;
   reg [1:0]  pin_sync_reg;
   reg        pin_prev_reg;
   reg [2:0]  pin_fill_reg;
   reg [1:0]  idle_sync_reg;
   reg [1:0]  gate_sync_reg;
   reg        gate_prev_reg;
   reg        aw_held_reg;
   reg [3:0]  aw_addr_reg;
   reg        w_held_reg;
   reg [31:0] w_data_reg;
   reg [3:0]  w_strb_reg;

   wire [15:0] eff_ctrl;
   wire        eff_run;
   wire        eff_idle_halt;
   wire        eff_gate;
   wire        eff_src_ext;
   wire        wide;
   wire        pin_rise;
   wire        active;
   wire        raw_tick;
   wire        pre_tick;
   wire        aw_ok;
   wire        w_ok;
   wire        do_write;
   wire [2:0]  aw_hit;

   // =====================================================================
   // helpers
   function [15:0] merge_strb;
      input [15:0] old_v;
      input [31:0] new_v;
      input [3:0]  strb;
      input [15:0] mask;
      reg   [15:0] tmp;
      begin
         tmp = old_v;
         if (strb[0])
            tmp[7:0] = new_v[7:0];
         if (strb[1])
            tmp[15:8] = new_v[15:8];
         merge_strb = tmp & mask;
      end
   endfunction

   // one-hot register select: bit 0 upper, bit 1 lower, bit 2 status
   function [2:0] reg_hit;
      input [3:0] a;
      begin
         case (a)
            `UHT_UPPER_CTRL_OFS: reg_hit = 3'h1;
            `UHT_LOWER_CTRL_OFS: reg_hit = 3'h2;
            `UHT_STATUS_OFS:     reg_hit = 3'h4;
            default:             reg_hit = 3'h0;
         endcase
      end
   endfunction

   function addr_known;
      input [3:0] a;
      begin
         addr_known = |reg_hit(a);
      end
   endfunction

   // =====================================================================
   // input synchronisers
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         pin_sync_reg  <= 2'h0;
         pin_prev_reg  <= 1'b0;
         pin_fill_reg  <= 3'h0;
         idle_sync_reg <= 2'h0;
         gate_sync_reg <= 2'h0;
         gate_prev_reg <= 1'b0;
      end
      else
      begin
         pin_sync_reg  <= {pin_sync_reg[0], external_count_pin_i}; // [R10]
         pin_prev_reg  <= pin_sync_reg[1];
         pin_fill_reg  <= {pin_fill_reg[1:0], 1'b1};
         idle_sync_reg <= {idle_sync_reg[0], cpu_idle_i};
         gate_sync_reg <= {gate_sync_reg[0], gate_in_i};
         gate_prev_reg <= gate_sync_reg[1];
      end
   end

   // at most one edge per peripheral clock after synchronising;
   // held off until both flops carry real pin samples, so a pin that
   // idles high gives no false edge after reset
   assign pin_rise = pin_fill_reg[2] & pin_sync_reg[1] &
                     ~pin_prev_reg; // [R10]

   // =====================================================================
   // effective control: lower register rules the pair
   assign wide     = lower_timer_control_reg[`UHT_PAIR_BIT]; // [R8]
   assign eff_ctrl = wide ? lower_timer_control_reg
                          : upper_timer_control_reg; // [R6]
   assign eff_run       = eff_ctrl[`UHT_RUN_BIT];
   assign eff_idle_halt = eff_ctrl[`UHT_IDLE_BIT];
   assign eff_src_ext   = eff_ctrl[`UHT_SRC_BIT];
   assign eff_gate      = eff_ctrl[`UHT_GATE_BIT] & ~eff_src_ext; // [R3]

   // pair in idle keeps running only if the lower idle bit is clear
   assign active = eff_run &                                // [R1]
                   ~(eff_idle_halt & idle_sync_reg[1]);    // [R2] [R7]

   // gating: count peripheral clocks only while the gate is high
   assign raw_tick = eff_src_ext ? pin_rise                 // [R5]
                   : (eff_gate ? gate_sync_reg[1] : 1'b1); // [R3] [R5]

   uht_prescaler u_pre
   (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .clear_i (~active),
      .tick_i  (raw_tick & active),
      .sel_i   (eff_ctrl[`UHT_PRE_HI:`UHT_PRE_LO]), // [R4]
      .tick_o  (pre_tick)
   );

   // =====================================================================
   // outputs to the counting core
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         upper_count_en_o <= 1'b0;
         gate_fall_o      <= 1'b0;
         pair_wide_mode_o <= 1'b0;
         pair_carry_sel_o <= 1'b0;
      end
      else
      begin
         // in the pair the core carries the low word into this high word
         upper_count_en_o <= pre_tick & ~wide;                  // [R9]
         gate_fall_o      <= eff_gate & active &
                             gate_prev_reg & ~gate_sync_reg[1]; // [R3]
         pair_wide_mode_o <= wide;                               // [R8]
         pair_carry_sel_o <= wide & pre_tick;                    // [R9]
      end
   end

   // =====================================================================
   // axi4-lite write channel; address and data taken in either order
   // nothing new is taken while a response waits: one write at a time
   assign aw_ok    = s_axi_awvalid & ~aw_held_reg & ~s_axi_awready &
                     ~s_axi_bvalid;
   assign w_ok     = s_axi_wvalid & ~w_held_reg & ~s_axi_wready &
                     ~s_axi_bvalid;
   assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
   assign aw_hit   = reg_hit(aw_addr_reg);

   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         s_axi_awready           <= 1'b0;
         s_axi_wready            <= 1'b0;
         s_axi_bvalid            <= 1'b0;
         s_axi_bresp             <= `UHT_RESP_OKAY;
         aw_held_reg             <= 1'b0;
         aw_addr_reg             <= 4'h0;
         w_held_reg              <= 1'b0;
         w_data_reg              <= 32'h0000_0000;
         w_strb_reg              <= 4'h0;
         upper_timer_control_reg <= `UHT_CTRL_RESET;
         lower_timer_control_reg <= `UHT_CTRL_RESET;
      end
      else
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         if (aw_ok)
         begin
            s_axi_awready <= 1'b1;
            aw_held_reg   <= 1'b1;
            aw_addr_reg   <= s_axi_awaddr;
         end
         if (w_ok)
         begin
            s_axi_wready <= 1'b1;
            w_held_reg   <= 1'b1;
            w_data_reg   <= s_axi_wdata;
            w_strb_reg   <= s_axi_wstrb;
         end
         // register and response move on one edge, so a read issued
         // after the answer always sees the new value
         if (do_write)
         begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_known(aw_addr_reg) ? `UHT_RESP_OKAY
                                                    : `UHT_RESP_SLVERR;
            if (aw_hit[0])
               upper_timer_control_reg <= merge_strb(
                  upper_timer_control_reg, w_data_reg, w_strb_reg,
                  `UHT_UPPER_MASK);
            if (aw_hit[1])
               lower_timer_control_reg <= merge_strb(
                  lower_timer_control_reg, w_data_reg, w_strb_reg,
                  `UHT_LOWER_MASK);
         end
         else if (s_axi_bvalid & s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // =====================================================================
   // axi4-lite read channel
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `UHT_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= 1'b0;
         if (s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid)
         begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= addr_known(s_axi_araddr) ? `UHT_RESP_OKAY
                                                      : `UHT_RESP_SLVERR;
            case (s_axi_araddr)
               `UHT_UPPER_CTRL_OFS:
                  s_axi_rdata <= {16'h0000, upper_timer_control_reg};
               `UHT_LOWER_CTRL_OFS:
                  s_axi_rdata <= {16'h0000, lower_timer_control_reg};
               `UHT_STATUS_OFS:
                  s_axi_rdata <= {28'h0000000, wide, idle_sync_reg[1],
                                  eff_src_ext, active};
               default:
                  s_axi_rdata <= 32'h0000_0000;
            endcase
         end
         else if (s_axi_rvalid & s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // uht_timer_ctrl

//--- rtl/uht_map.vh
// register offsets, field positions and reset values for the upper timer
// control block; included by the block's design files
`ifndef UHT_MAP_VH
`define UHT_MAP_VH

// byte offsets on the register bus
`define UHT_UPPER_CTRL_OFS   4'h0
`define UHT_LOWER_CTRL_OFS   4'h4
`define UHT_STATUS_OFS       4'h8

// control word fields (upper and lower share the layout)
`define UHT_RUN_BIT          15
`define UHT_IDLE_BIT         13
`define UHT_GATE_BIT         6
`define UHT_PRE_HI           5
`define UHT_PRE_LO           4
`define UHT_PAIR_BIT         3
`define UHT_SRC_BIT          1

// writable bit masks; all other bits read as zero
`define UHT_UPPER_MASK       16'hA072
`define UHT_LOWER_MASK       16'hA07A
`define UHT_CTRL_RESET       16'h0000

// prescale terminal counts (ratio minus one)
`define UHT_DIV1_LAST        8'h00
`define UHT_DIV8_LAST        8'h07
`define UHT_DIV64_LAST       8'h3F
`define UHT_DIV256_LAST      8'hFF

// bus responses
`define UHT_RESP_OKAY        2'h0
`define UHT_RESP_SLVERR      2'h2

`endif

//--- rtl/uht_prescaler.v
// input prescaler: divides a stream of count-enable pulses by 1, 8, 64
// or 256; assumes same-clock pulses and a synchronous clear
`timescale 1ns/1ps
`include "uht_map.vh"

module uht_prescaler
(
   input  wire       clk_i,      // peripheral clock
   input  wire       nrst_i,     // async reset, active low
   input  wire       clear_i,    // restart the division
   input  wire       tick_i,     // one input clock event
   input  wire [1:0] sel_i,      // prescale code
   output reg        tick_o      // divided event pulse
);

   reg [7:0] cnt_reg;
   reg [7:0] cnt_next;
   reg       tick_next;

   // =====================================================================
   // terminal count lookup
   function [7:0] last_count;
      input [1:0] code;
      begin
         case (code)
            2'h3:    last_count = `UHT_DIV256_LAST;
            2'h2:    last_count = `UHT_DIV64_LAST;
            2'h1:    last_count = `UHT_DIV8_LAST;
            default: last_count = `UHT_DIV1_LAST;
         endcase
      end
   endfunction

   // =====================================================================
   // divider
   always @*
   begin
      cnt_next  = cnt_reg;
      tick_next = 1'b0;
      if (clear_i)
      begin
         cnt_next = 8'h00;
      end
      else if (tick_i)
      begin
         // >= covers a code lowered mid-count
         if (cnt_reg >= last_count(sel_i)) // [R4]
         begin
            cnt_next  = 8'h00;
            tick_next = 1'b1;
         end
         else
         begin
            cnt_next = cnt_reg + 8'h01;
         end
      end
   end

   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cnt_reg <= 8'h00;
         tick_o  <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         tick_o  <= tick_next;
      end
   end

endmodule // uht_prescaler

//--- test/uht_timer_ctrl_props.sv
// =====================================================
// checker for the upper timer control block
// sees only the top ports; shadows byte lanes 0 and 1 of each write
`timescale 1ns/1ps
`include "uht_map.vh"

module uht_timer_ctrl_props
(
   input wire        clk_i,            // clock
   input wire        nrst_i,           // reset
   input wire [3:0]  s_axi_awaddr,     // aw
   input wire        s_axi_awvalid,    // aw
   input wire        s_axi_awready,    // aw
   input wire [31:0] s_axi_wdata,      // w
   input wire [3:0]  s_axi_wstrb,      // w
   input wire        s_axi_wvalid,     // w
   input wire        s_axi_wready,     // w
   input wire [1:0]  s_axi_bresp,      // b
   input wire        s_axi_bvalid,     // b
   input wire        s_axi_bready,     // b
   input wire [3:0]  s_axi_araddr,     // ar
   input wire        s_axi_arvalid,    // ar
   input wire        s_axi_arready,    // ar
   input wire [31:0] s_axi_rdata,      // r
   input wire [1:0]  s_axi_rresp,      // r
   input wire        s_axi_rvalid,     // r
   input wire        cpu_idle_i,       // idle
   input wire        gate_in_i,        // gate
   input wire        upper_count_en_o, // count
   input wire        gate_fall_o,      // gate end
   input wire        pair_wide_mode_o, // pair
   input wire        pair_carry_sel_o  // low tick
);
   // =====================================================
   // shadow registers
   logic [15:0] up_sh, lo_sh;
   logic [2:0]  age;
   wire wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire ar_hs = s_axi_arvalid && s_axi_arready;
   // age saturates: settled control after seven quiet cycles
   wire own = !lo_sh[`UHT_PAIR_BIT] && age == 3'h7;

   // lane 0 carries bits 7:0, lane 1 bits 15:8
   function automatic logic [15:0] mrg(input logic [15:0] o,
      input logic [15:0] n, input logic [3:0] s);
      return {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
   endfunction

   always @(posedge clk_i or negedge nrst_i)
      if (!nrst_i)
      begin
         up_sh <= 16'h0;
         lo_sh <= 16'h0;
         age   <= 3'h0;
      end
      else if (wr_hs)
      begin
         age <= 3'h0;
         if (s_axi_awaddr == 4'h0)
            up_sh <= mrg(up_sh, s_axi_wdata[15:0], s_axi_wstrb)
                     & `UHT_UPPER_MASK;
         if (s_axi_awaddr == 4'h4)
            lo_sh <= mrg(lo_sh, s_axi_wdata[15:0], s_axi_wstrb)
                     & `UHT_LOWER_MASK;
      end
      else if (age != 3'h7)
         age <= age + 3'h1;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   // =====================================================
   // assertions
   a_rd_answer: assert property (ar_hs |-> s_axi_rvalid)
      else $error("read answer late");
   a_wr_answer: assert property (wr_hs |=> s_axi_bvalid)
      else $error("write answer late");
   a_b_stands: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   a_unmap_wr: assert property (wr_hs && s_axi_awaddr[3:2] == 2'h3
      |=> s_axi_bresp == `UHT_RESP_SLVERR) else $error("unmapped write ok");
   a_unmap_rd: assert property (ar_hs && s_axi_araddr[3:2] == 2'h3
      |-> s_axi_rresp == `UHT_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read ok");
   a_upper_rd: assert property (
      ar_hs && s_axi_araddr == 4'h0 |-> s_axi_rdata == {16'h0, up_sh})
      else $error("upper control readback");
   a_pair_mode: assert property (
      age == 3'h7 |-> pair_wide_mode_o == lo_sh[`UHT_PAIR_BIT])
      else $error("pair mode flag");
   a_pair_quiet: assert property (
      pair_wide_mode_o |-> !upper_count_en_o) else $error("upper counts in pair");
   a_stop_quiet: assert property (
      own && !up_sh[`UHT_RUN_BIT] |-> !upper_count_en_o)
      else $error("counts while stopped");
   a_run_every: assert property (
      own && up_sh == 16'h8000 |-> upper_count_en_o) else $error("1:1 missed");
   a_idle_halt: assert property (
      (own && up_sh[`UHT_IDLE_BIT] && cpu_idle_i)[*7] |-> !upper_count_en_o)
      else $error("counts in idle");
   a_gate_fall: assert property (
      own && up_sh == 16'h8040 && $fell(gate_in_i) |-> ##[1:6] gate_fall_o)
      else $error("gate end missed");

   c_pair: cover property (pair_carry_sel_o);
   c_gate: cover property (gate_fall_o);
   c_ext:  cover property (upper_count_en_o && up_sh[`UHT_SRC_BIT]);
endmodule // uht_timer_ctrl_props

bind uht_timer_ctrl uht_timer_ctrl_props u_props (.*);

//--- test/tb_uht_timer_ctrl.sv
// =====================================================
// self-checking bench for the upper timer control block
// drives bus and timer inputs itself; results checked via a queue
`timescale 1ns/1ps
`include "uht_map.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
   num_errors++; $display("wrong value at %0t: got %h exp %h", \
   $time, g, e); end end

module tb_uht_timer_ctrl;
   logic        clk_i = 1'b0, nrst_i = 1'b0;
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cpu_idle_i = 1'b0;
   logic        gate_in_i = 1'b0, external_count_pin_i = 1'b0;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire         s_axi_rvalid, upper_count_en_o, gate_fall_o;
   wire         pair_wide_mode_o, pair_carry_sel_o;
   wire [1:0]   s_axi_bresp, s_axi_rresp;
   wire [31:0]  s_axi_rdata;
   logic [33:0] q[$];
   logic [33:0] ex;
   logic [15:0] cu = 16'h0, cp = 16'h0, d;
   logic        win = 1'b0, win_d = 1'b0, pin_en = 1'b0;
   logic [1:0]  pd = 2'h0;
   integer      num_errors = 0, samples_checked = 0, cyc = 0, i;
   integer      seed = 32'h7669;

   uht_timer_ctrl dut (.*);

   initial
   begin
      forever #5 clk_i = ~clk_i;
   end

   task end_of_test;
      if (q.size() != 0)
         num_errors++;
      $display("checked %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // =====================================================
   // bus tasks: each starts one edge later so no signal is set twice
   task automatic wr(input [3:0] a, input [15:0] v, input [1:0] e);
      @(posedge clk_i);
      q.push_back({e, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk_i);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input [3:0] a, input [15:0] v, input [1:0] e);
      @(posedge clk_i);
      q.push_back({e, 16'h0, v});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk_i);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask

   // counts pulses over a window once the control has settled
   task automatic meas(input integer len, input [15:0] eu, input [15:0] ep);
      repeat (12) @(posedge clk_i);
      q.push_back({2'h0, eu, ep});
      win <= 1'b1;
      repeat (len) @(posedge clk_i);
      win <= 1'b0;
   endtask

   task note(input string s);
      $display("test done: %s", s);
   endtask

   // =====================================================
   // monitor: compares each result with the oldest note
   always @(posedge clk_i)
   begin
      win_d <= win;
      cyc++;
      if (win)
      begin
         cu <= cu + {15'h0, upper_count_en_o};
         cp <= cp + {15'h0, pair_carry_sel_o};
      end
      else
      begin
         if (win_d)
         begin
            ex = q.pop_front();
            `CHK({2'h0, cu, cp}, ex)
         end
         cu <= 16'h0;
         cp <= 16'h0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
         ex = q.pop_front();
         `CHK({s_axi_bresp, 32'h0}, ex)
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
         ex = q.pop_front();
         `CHK({s_axi_rresp, s_axi_rdata}, ex)
      end
      if (cyc == 8000)
      begin
         num_errors++;
         end_of_test;
      end
   end

   // external pin: rising edge every eight clocks while enabled
   always @(posedge clk_i)
   begin
      pd <= pd + 2'h1;
      if (pin_en && pd == 2'h3) external_count_pin_i <= ~external_count_pin_i;
   end

   initial
   begin
      repeat (10) @(posedge clk_i);
      nrst_i <= 1'b1;
      rd(4'h0, 16'h0, `UHT_RESP_OKAY);
      rd(4'h4, 16'h0, `UHT_RESP_OKAY);
      wr(4'hC, 16'hFFFF, `UHT_RESP_SLVERR);
      rd(4'hC, 16'h0, `UHT_RESP_SLVERR);
      for (i = 0; i < 4; i++)
      begin
         d = $random(seed);
         wr(4'h0, d, `UHT_RESP_OKAY);
         rd(4'h0, d & `UHT_UPPER_MASK, `UHT_RESP_OKAY);
      end
      wr(4'h0, 16'h0, `UHT_RESP_OKAY);
      s_axi_wstrb <= 4'h2;
      wr(4'h0, 16'hFFFF, `UHT_RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      rd(4'h0, 16'hA000, `UHT_RESP_OKAY);
      note("registers");
      for (i = 0; i < 4; i++)
      begin
         wr(4'h0, {10'h200, i[1:0], 4'h0}, `UHT_RESP_OKAY);
         meas(4 * ((i == 3) ? 256 : 1 << (3 * i)), 16'h4, 16'h0);
      end
      wr(4'h0, 16'h0, `UHT_RESP_OKAY);
      meas(64, 16'h0, 16'h0);
      note("prescale and stop");
      cpu_idle_i <= 1'b1;
      wr(4'h0, 16'hA000, `UHT_RESP_OKAY);
      meas(64, 16'h0, 16'h0);
      wr(4'h0, 16'h8000, `UHT_RESP_OKAY);
      meas(16, 16'h10, 16'h0);
      cpu_idle_i <= 1'b0;
      wr(4'h0, 16'h8040, `UHT_RESP_OKAY);
      meas(32, 16'h0, 16'h0);
      gate_in_i <= 1'b1;
      meas(16, 16'h10, 16'h0);
      gate_in_i <= 1'b0;
      meas(32, 16'h0, 16'h0);
      pin_en <= 1'b1;
      wr(4'h0, 16'h8042, `UHT_RESP_OKAY);
      meas(64, 16'h8, 16'h0);
      wr(4'h0, 16'h8052, `UHT_RESP_OKAY);
      meas(256, 16'h4, 16'h0);
      rd(4'h8, 16'h3, `UHT_RESP_OKAY);
      pin_en <= 1'b0;
      note("idle gate source");
      wr(4'h0, 16'h8000, `UHT_RESP_OKAY);
      wr(4'h4, 16'h8018, `UHT_RESP_OKAY);
      meas(32, 16'h0, 16'h4);
      cpu_idle_i <= 1'b1;
      wr(4'h4, 16'hA008, `UHT_RESP_OKAY);
      meas(32, 16'h0, 16'h0);
      rd(4'h8, 16'hC, `UHT_RESP_OKAY);
      wr(4'h4, 16'h8008, `UHT_RESP_OKAY);
      meas(16, 16'h0, 16'h10);
      wr(4'h4, 16'h0, `UHT_RESP_OKAY);
      meas(16, 16'h10, 16'h0);
      cpu_idle_i <= 1'b0;
      note("pair");
      repeat (4) @(posedge clk_i);
      end_of_test;
   end
endmodule // tb_uht_timer_ctrl
